// ==== logic/channel_osc_ctrl.sv ====
// Channel oscillator tuning, phase and input control
//
// Function
// - Low tuning half shadowed at 0x85
// - High tuning half shadowed at 0x86
// - Shadow moves on wake or sync
// - Sync update when hold-off reaches one
// - Hold-off one: update on shadow write
// - Sixteen-bit phase offset, under full cycle
// - Nine-bit control word at 0x88
// - Bits 8-7 pick sync pin
// - Bit 6 picks port A or B
// - Mode 00: full rate, mask low
// - Mode 01: take when enable high
// - Mode 10: take after rising enable
// - Mode 11: take after falling enable
// - Bit 3 clears accumulator on hop
// - Hop from software or pin sync
// - Bits 2-1 enable oscillator dithers
// - Bit 0 bypass: A to I, B to Q
// - Bit 2 amplitude, bit 1 phase dither
// - Hold-off 0x84 counts; zero suppresses hop
`timescale 1ns/10ps
`default_nettype none

module channel_osc_ctrl
  import osc_ctrl_pkg::*;
#(
  parameter int FIFO_DEPTH = 8 // Sample buffer entries
) (
  input  wire logic             clk,          // Sample clock, 100 MHz
  input  wire logic             srst,         // Synchronous reset
  input  wire logic [7:0]       regAddr,      // Channel address
  input  wire logic [15:0]      regWrData,    // Write data
  input  wire logic             regWr,        // Write strobe
  input  wire logic             regRd,        // Read strobe
  output logic      [15:0]      regRdData,    // Read data
  input  wire logic [3:0]       syncPin,      // Timing pulse pins
  input  wire port_sample_type  portA,        // Port A sample
  input  wire logic             sampleEnA,    // Port A sample enable
  input  wire port_sample_type  portB,        // Port B sample
  input  wire logic             sampleEnB,    // Port B sample enable
  output chan_sample_type       outSample,    // Qualified sample
  output logic                  outValid,     // Sample present
  input  wire logic             outReady,     // Downstream accepts
  output logic                  ampDither,    // Amplitude dither on
  output logic                  phaseDither,  // Phase dither on
  output logic                  lowPowerHold  // Channel asleep
);

  // ----------------------------------------------------------
  // Register file
  // ----------------------------------------------------------
  logic [15:0]         tuneLow_r;     // Shadow low half
  logic [15:0]         tuneHigh_r;    // Shadow high half
  logic [15:0]         phaseOff_r;    // Phase offset
  logic [CTL_WIDTH-1:0] control_r;    // Control word
  logic [15:0]         holdOff_r;     // Hold-off reload value
  logic                sleep_r;       // Low power hold
  logic                pinHopEn_r;    // Pin sync starts hops
  logic                overflow_r;    // Sample lost, sticky

  logic wrSleep;    // Sleep register written
  logic wrSoft;     // Soft sync written
  logic wrLow;      // Low half written
  logic wrHigh;     // High half written
  logic wrStatus;   // Status written

  assign wrSleep  = regWr && regAddr == ADDR_SLEEP;
  assign wrSoft   = regWr && regAddr == ADDR_SOFT_SYNC;
  assign wrLow    = regWr && regAddr == ADDR_TUNE_LO;
  assign wrHigh   = regWr && regAddr == ADDR_TUNE_HI;
  assign wrStatus = regWr && regAddr == ADDR_STATUS;

  // Configuration register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      tuneLow_r  <= RST_HALF;
      tuneHigh_r <= RST_HALF;
      phaseOff_r <= RST_HALF;
      control_r  <= RST_CONTROL;
      holdOff_r  <= RST_HALF;
      pinHopEn_r <= 1'b0;
    end else if (regWr) begin
      unique case (regAddr)
        ADDR_TUNE_LO: tuneLow_r <= regWrData;
        ADDR_TUNE_HI: tuneHigh_r <= regWrData;
        ADDR_PHASE: phaseOff_r <= regWrData;
        ADDR_CONTROL: control_r <= regWrData[CTL_WIDTH-1:0];
        ADDR_HOLD_OFF: holdOff_r <= regWrData;
        ADDR_PIN_SYNC: pinHopEn_r <= regWrData[SYNC_HOP_BIT];
        default: ;
      endcase
    end
  end

  // Sleep bit
  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_r <= RST_SLEEP;
    end else if (wrSleep) begin
      sleep_r <= regWrData[0];
    end
  end

  // ----------------------------------------------------------
  // Control word decode
  // ----------------------------------------------------------
  logic [1:0]    syncSel;  // Selected sync pin
  logic          usePortB; // Port B routed in
  qual_mode_type qualMode; // Qualification mode
  logic          clrOnHop; // Clear accumulator on hop
  logic          bypass;   // Translation skipped

  assign syncSel  = control_r[CTL_SYNC_HI:CTL_SYNC_LO];
  assign usePortB = control_r[CTL_PORT_B];
  assign qualMode = qual_mode_type'(control_r[CTL_QUAL_HI:CTL_QUAL_LO]);
  assign clrOnHop = control_r[CTL_CLR_ACC];
  assign bypass   = control_r[CTL_BYPASS];

  // ----------------------------------------------------------
  // Sync pin capture
  // ----------------------------------------------------------
  logic [3:0] syncMeta_r;  // First synchroniser stage
  logic [3:0] syncSafe_r;  // Second synchroniser stage
  logic [3:0] syncPrev_r;  // Previous safe level

  // Two-stage synchroniser and edge history
  always_ff @(posedge clk) begin
    if (srst) begin
      syncMeta_r <= '0;
      syncSafe_r <= '0;
      syncPrev_r <= '0;
    end else begin
      syncMeta_r <= syncPin;
      syncSafe_r <= syncMeta_r;
      syncPrev_r <= syncSafe_r;
    end
  end

  logic pinPulse; // Rising edge on selected pin
  assign pinPulse = syncSafe_r[syncSel] && !syncPrev_r[syncSel];

  // ----------------------------------------------------------
  // Frequency hop sequencing
  // ----------------------------------------------------------
  logic        syncEvent;  // Hop request this cycle
  logic [15:0] holdCnt_r;  // Hold-off countdown
  logic        holdBusy_r; // Countdown running
  logic        hopNow;     // Sync driven transfer
  logic        wakeNow;    // Leaving low power hold
  logic        writeNow;   // Immediate transfer on write

  assign syncEvent = (wrSoft && regWrData[SYNC_HOP_BIT]) ||
                     (pinHopEn_r && pinPulse);

  assign hopNow = (syncEvent && holdOff_r == HOLD_NOW) ||
                  (holdBusy_r && holdCnt_r == HOLD_NOW);

  assign wakeNow = wrSleep && sleep_r && !regWrData[0];

  assign writeNow = (wrLow || wrHigh) && holdOff_r == HOLD_NOW;

  // Hold-off counter
  always_ff @(posedge clk) begin
    if (srst) begin
      holdCnt_r  <= HOLD_NONE;
      holdBusy_r <= 1'b0;
    end else if (syncEvent) begin
      holdCnt_r  <= holdOff_r;
      holdBusy_r <= holdOff_r > HOLD_NOW;
    end else if (holdBusy_r) begin
      if (holdCnt_r == HOLD_NOW) begin
        holdBusy_r <= 1'b0;
      end else begin
        holdCnt_r <= holdCnt_r - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------
  // Active tuning word
  // ----------------------------------------------------------
  logic [31:0] activeTune_r; // Word used by the accumulator
  logic [31:0] shadowNew;    // Shadow including this write

  // Shadow as it stands after the current write
  always_comb begin
    shadowNew = {tuneHigh_r, tuneLow_r};
    if (wrLow) begin
      shadowNew[15:0] = regWrData;
    end
    if (wrHigh) begin
      shadowNew[31:16] = regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      activeTune_r <= '0;
    end else if (hopNow || wakeNow || writeNow) begin
      activeTune_r <= shadowNew;
    end
  end

  // ----------------------------------------------------------
  // Input capture and qualification
  // ----------------------------------------------------------
  port_sample_type capA_r;    // Captured port A
  port_sample_type capB_r;    // Captured port B
  logic            capEnA_r;  // Captured enable A
  logic            capEnB_r;  // Captured enable B

  // Input ports are registered on the sample clock
  always_ff @(posedge clk) begin
    if (srst) begin
      capA_r   <= '0;
      capB_r   <= '0;
      capEnA_r <= 1'b0;
      capEnB_r <= 1'b0;
    end else begin
      capA_r   <= portA;
      capB_r   <= portB;
      capEnA_r <= sampleEnA;
      capEnB_r <= sampleEnB;
    end
  end

  logic take;      // Qualified sample
  logic zeroData;  // Masked sample
  logic enableSel; // Enable of chosen port

  assign enableSel = usePortB ? capEnB_r : capEnA_r;

  sample_qualifier u_qual (
    .clk      (clk),
    .srst     (srst),
    .mode     (qualMode),
    .enableIn (enableSel),
    .take     (take),
    .zeroData (zeroData)
  );

  // ----------------------------------------------------------
  // Phase accumulator and sample assembly
  // ----------------------------------------------------------
  logic            fifoInReady; // Buffer has space
  logic            push;        // Sample written to buffer
  logic            lost;        // Sample dropped on full buffer
  logic [31:0]     acc_r;       // Phase accumulator
  chan_sample_type sample;      // Sample being buffered

  assign push = take && !sleep_r && fifoInReady;
  assign lost = take && !sleep_r && !fifoInReady;

  // Accumulator advances only on buffered samples
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_r <= '0;
    end else if (hopNow && clrOnHop) begin
      acc_r <= '0;
    end else if (push) begin
      acc_r <= acc_r + activeTune_r;
    end
  end

  // Sample carrier
  always_comb begin
    sample            = '0;
    sample.bypass     = bypass;
    sample.phase      = acc_r[31:16] + phaseOff_r;
    if (bypass) begin
      // A to I, B to Q
      sample.inPhase    = capA_r;
      sample.quadrature = capB_r;
    end else begin
      sample.inPhase = usePortB ? capB_r : capA_r;
    end
    if (zeroData) begin
      sample.inPhase    = '0;
      sample.quadrature = '0;
    end
  end

  // ----------------------------------------------------------
  // Sample buffer and output register
  // ----------------------------------------------------------
  logic [SAMPLE_W-1:0] fifoOut;    // Buffer head
  logic                fifoValid;  // Buffer not empty
  logic                fifoPop;    // Head moves to output

  assign fifoPop = fifoValid && (!outValid || outReady);

  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .srst     (srst),
    .inData   (sample),
    .inValid  (take && !sleep_r),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // Output holding register
  always_ff @(posedge clk) begin
    if (srst) begin
      outValid  <= 1'b0;
      outSample <= '0;
    end else if (fifoPop) begin
      outValid  <= 1'b1;
      outSample <= chan_sample_type'(fifoOut);
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

  // Overflow flag, a new loss wins over a clear
  always_ff @(posedge clk) begin
    if (srst) begin
      overflow_r <= 1'b0;
    end else if (lost) begin
      overflow_r <= 1'b1;
    end else if (wrStatus && regWrData[0]) begin
      overflow_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Status outputs and read port
  // ----------------------------------------------------------
  // Registered configuration outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      ampDither    <= 1'b0;
      phaseDither  <= 1'b0;
      lowPowerHold <= RST_SLEEP;
    end else begin
      // bit 2 amplitude, bit 1 phase
      ampDither    <= control_r[CTL_AMP_DITH];
      phaseDither  <= control_r[CTL_PHS_DITH];
      lowPowerHold <= sleep_r;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdData <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_SLEEP:    regRdData <= {15'h0000, sleep_r};
        ADDR_PIN_SYNC: regRdData <= {14'h0000, pinHopEn_r, 1'b0};
        ADDR_HOLD_OFF: regRdData <= holdOff_r;
        ADDR_TUNE_LO:  regRdData <= tuneLow_r;
        ADDR_TUNE_HI:  regRdData <= tuneHigh_r;
        ADDR_PHASE:    regRdData <= phaseOff_r;
        ADDR_CONTROL:  regRdData <= {7'h00, control_r};
        ADDR_STATUS:   regRdData <= {13'h0000, holdBusy_r, fifoValid, overflow_r};
        default:       regRdData <= '0;
      endcase
    end
  end

endmodule : channel_osc_ctrl

`default_nettype wire

// ==== logic/osc_ctrl_pkg.sv ====
// Package: addresses, fields, reset values and carriers for the oscillator input control
package osc_ctrl_pkg;

  // ----------------------------------------------------------
  // Channel register addresses
  // ----------------------------------------------------------
  localparam logic [7:0] ADDR_SLEEP     = 8'h80; // Channel low power hold
  localparam logic [7:0] ADDR_SOFT_SYNC = 8'h81; // Software sync strobe
  localparam logic [7:0] ADDR_PIN_SYNC  = 8'h82; // Pin sync enables
  localparam logic [7:0] ADDR_HOLD_OFF  = 8'h84; // Frequency hold-off value
  localparam logic [7:0] ADDR_TUNE_LO   = 8'h85; // Tuning word low half
  localparam logic [7:0] ADDR_TUNE_HI   = 8'h86; // Tuning word high half
  localparam logic [7:0] ADDR_PHASE     = 8'h87; // Phase offset
  localparam logic [7:0] ADDR_CONTROL   = 8'h88; // Channel control word
  localparam logic [7:0] ADDR_STATUS    = 8'h89; // Block status

  // ----------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------
  localparam int SYNC_HOP_BIT   = 1; // Hop bit in sync registers
  localparam int CTL_SYNC_HI    = 8; // Sync pin select, upper bit
  localparam int CTL_SYNC_LO    = 7; // Sync pin select, lower bit
  localparam int CTL_PORT_B     = 6; // Input port select
  localparam int CTL_QUAL_HI    = 5; // Sample qualify, upper bit
  localparam int CTL_QUAL_LO    = 4; // Sample qualify, lower bit
  localparam int CTL_CLR_ACC    = 3; // Clear accumulator on hop
  localparam int CTL_AMP_DITH   = 2; // Amplitude dither enable
  localparam int CTL_PHS_DITH   = 1; // Phase dither enable
  localparam int CTL_BYPASS     = 0; // Frequency translation bypass
  localparam int CTL_WIDTH      = 9; // Control word width

  // ----------------------------------------------------------
  // Reset values and hold-off codes
  // ----------------------------------------------------------
  localparam logic [15:0] RST_HALF    = 16'h0000; // 16-bit registers
  localparam logic [8:0]  RST_CONTROL = 9'h000;   // Control word
  localparam logic        RST_SLEEP   = 1'b1;     // Channel asleep
  localparam logic [15:0] HOLD_NONE   = 16'h0000; // Hop suppressed
  localparam logic [15:0] HOLD_NOW    = 16'h0001; // Immediate update

  // Sample qualification modes
  typedef enum logic [1:0] {
    QUAL_MASK = 2'b00, // Full rate, mask on enable low
    QUAL_HIGH = 2'b01, // Take on enable high
    QUAL_RISE = 2'b10, // Take after rising enable
    QUAL_FALL = 2'b11  // Take after falling enable
  } qual_mode_type;

  // One input port sample
  typedef struct packed {
    logic [13:0] mantissa; // Input mantissa
    logic [2:0]  exponent; // Input exponent
  } port_sample_type;

  // One qualified channel sample with oscillator phase
  typedef struct packed {
    port_sample_type inPhase;    // In-phase input
    port_sample_type quadrature; // Quadrature input, bypass only
    logic [15:0]     phase;      // Oscillator phase with offset
    logic            bypass;     // Translation skipped
  } chan_sample_type;

  localparam int SAMPLE_W = $bits(chan_sample_type); // Carrier width

endpackage : osc_ctrl_pkg

// ==== logic/sample_fifo.sv ====
// Synchronous FIFO carrying channel samples
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 8, // Word width
  parameter int DEPTH = 8  // Entries, power of two
) (
  input  wire logic             clk,     // Sample clock
  input  wire logic             srst,    // Synchronous reset
  input  wire logic [WIDTH-1:0] inData,  // Write word
  input  wire logic             inValid, // Write request
  output logic                  inReady, // Space available
  output logic [WIDTH-1:0]      outData, // Head word
  output logic                  outValid, // Not empty
  input  wire logic             outReady  // Read accept
);

  localparam int AW = $clog2(DEPTH); // Address width; pointers carry one more bit

  // Refuse sizes the pointers cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
    $error("sample_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];   // Storage
  logic [AW:0]      wrPtr_r;       // Write pointer with wrap bit
  logic [AW:0]      rdPtr_r;       // Read pointer with wrap bit
  logic             push;          // Write accepted
  logic             pop;           // Read accepted

  // Full when pointers differ only in the wrap bit
  assign inReady  = (wrPtr_r ^ rdPtr_r) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr_r != rdPtr_r;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_r[AW-1:0]];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  // Pointer update
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + 1'b1;
      if (pop)  rdPtr_r <= rdPtr_r + 1'b1;
    end
  end

endmodule : sample_fifo

`default_nettype wire

// ==== logic/sample_qualifier.sv ====
// Sample qualification from the sample enable pin
`timescale 1ns/10ps
`default_nettype none

module sample_qualifier
  import osc_ctrl_pkg::*;
(
  input  wire logic          clk,      // Sample clock
  input  wire logic          srst,     // Synchronous reset
  input  wire qual_mode_type mode,     // Qualification mode
  input  wire logic          enableIn, // Captured sample enable
  output logic               take,     // Sample accepted this cycle
  output logic               zeroData  // Force data to zero
);

  logic enablePrev_r; // Enable one capture earlier

  // Previous enable for edge detection
  always_ff @(posedge clk) begin
    if (srst) begin
      enablePrev_r <= 1'b0;
    end else begin
      enablePrev_r <= enableIn;
    end
  end

  // Mode decode
  always_comb begin
    zeroData = 1'b0;
    unique case (mode)
      QUAL_MASK: begin
        take     = 1'b1;
        zeroData = !enableIn;
      end
      QUAL_HIGH: take = enableIn;
      QUAL_RISE: take = enableIn && !enablePrev_r;
      QUAL_FALL: take = !enableIn && enablePrev_r;
    endcase
  end

endmodule : sample_qualifier

`default_nettype wire

// ==== bench/adc_source_model.sv ====
// Behavioural converter driving both input ports
`timescale 1ns/10ps
`default_nettype none
module adc_source_model
  import osc_ctrl_pkg::*;
(
  input  wire logic          clk,       // Sample clock
  output var port_sample_type portA,    // Port A sample
  output var logic           sampleEnA, // Port A enable
  output var port_sample_type portB,    // Port B sample
  output var logic           sampleEnB  // Port B enable
);
  logic [13:0] mant; // Fresh mantissa
  initial {portA, portB, sampleEnA, sampleEnB} = '0;
  // New sample each edge; B is A inverted with its own exponent so ports can be told apart
  always @(posedge clk) begin
    mant = 14'($urandom);
    portA     <= '{mantissa: mant, exponent: 3'h1};
    portB     <= '{mantissa: ~mant, exponent: 3'h6};
    sampleEnA <= 1'($urandom);
    sampleEnB <= 1'($urandom);
  end
endmodule : adc_source_model
`default_nettype wire

// ==== bench/channel_osc_ctrl_monitor.sv ====
// Assertion checker for the channel oscillator input control
`timescale 1ns/10ps
`default_nettype none
module channel_osc_ctrl_monitor
  import osc_ctrl_pkg::*;
(
  input wire logic            clk,
  input wire logic            srst,
  input wire logic [7:0]      regAddr,
  input wire logic [15:0]     regWrData,
  input wire logic            regWr,
  input wire logic            regRd,
  input wire logic [15:0]     regRdData,
  input wire chan_sample_type outSample,
  input wire logic            outValid,
  input wire logic            outReady,
  input wire logic            ampDither,
  input wire logic            phaseDither,
  input wire logic            lowPowerHold
);
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Write to one address, then a read of it
  sequence s_wr_rd(logic [7:0] a);
    regWr && regAddr == a ##2 regRd && regAddr == a;
  endsequence
  property p_rst_vals;
    $fell(srst) |-> lowPowerHold && !outValid && !ampDither && regRdData == 16'h0000;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset state");
  property p_sleep;
    regWr && regAddr == ADDR_SLEEP |-> ##2 lowPowerHold == $past(regWrData[0], 2);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flag");
  property p_tune_lo;
    s_wr_rd(ADDR_TUNE_LO) |=> regRdData == $past(regWrData, 3);
  endproperty
  a_tune_lo: assert property (p_tune_lo) else $error("low half readback");
  property p_tune_hi;
    s_wr_rd(ADDR_TUNE_HI) |=> regRdData == $past(regWrData, 3);
  endproperty
  a_tune_hi: assert property (p_tune_hi) else $error("high half readback");
  property p_phase;
    s_wr_rd(ADDR_PHASE) |=> regRdData == $past(regWrData, 3);
  endproperty
  a_phase: assert property (p_phase) else $error("phase readback");
  property p_ctl;
    s_wr_rd(ADDR_CONTROL) |=> regRdData == ($past(regWrData, 3) & 16'h01ff);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control readback");
  property p_unmapped;
    regRd && regAddr == 8'h8f |=> regRdData == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_dither;
    regWr && regAddr == ADDR_CONTROL |-> ##2 {ampDither, phaseDither} == $past(regWrData[2:1], 2);
  endproperty
  a_dither: assert property (p_dither) else $error("dither enables");
  property p_hold;
    outValid && !outReady |=> outValid && $stable(outSample);
  endproperty
  a_hold: assert property (p_hold) else $error("sample dropped");
endmodule : channel_osc_ctrl_monitor
bind channel_osc_ctrl channel_osc_ctrl_monitor mon_u (.clk(clk), .srst(srst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .outSample(outSample),
  .outValid(outValid), .outReady(outReady), .ampDither(ampDither), .phaseDither(phaseDither),
  .lowPowerHold(lowPowerHold));
`default_nettype wire

// ==== bench/channel_osc_ctrl_tb_top.sv ====
// Self-checking bench for the channel oscillator input control
`timescale 1ns/10ps
`default_nettype none
module channel_osc_ctrl_tb_top
  import osc_ctrl_pkg::*;
;
  // ------------------------------
  // Signals and expectations
  // ------------------------------
  logic clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, outReady = 1'b0, rdPend = 1'b0;
  logic stall = 1'b0, cnting = 1'b0, enPrev = 1'b0, enSel, ok, outValid, ampDither, phaseDither, lowPowerHold;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000, regRdData, offExp, phExp;
  logic [31:0] wExp, accExp = 32'h0;
  logic [8:0] ctrlExp = 9'h000;
  logic [3:0] syncPins = 4'h0; // Timing pulse pins from the bench
  logic [8:0] runCtl [5] = '{9'h00e, 9'h050, 9'h128, 9'h1f0, 9'h011}; // Control word per run
  logic [15:0] rdQ [$]; // Expected read data
  int fails = 0, nTests = 0, gotCnt = 0, expCnt = 0;
  port_sample_type portA, portB;
  logic sampleEnA, sampleEnB;
  chan_sample_type outSample;
  channel_osc_ctrl #(.FIFO_DEPTH(8)) dut_u (.clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .syncPin(syncPins), .portA(portA), .sampleEnA(sampleEnA),
    .portB(portB), .sampleEnB(sampleEnB), .outSample(outSample), .outValid(outValid), .outReady(outReady),
    .ampDither(ampDither), .phaseDither(phaseDither), .lowPowerHold(lowPowerHold));
  adc_source_model adc_u (.clk(clk), .portA(portA), .sampleEnA(sampleEnA), .portB(portB), .sampleEnB(sampleEnB));
  initial forever #5 clk = ~clk;
  // Far side stalls three cycles in four when asked
  always @(posedge clk) outReady <= stall ? ($urandom_range(3) == 0) : 1'b1;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    rdQ.push_back(e);
    @(posedge clk);
    regRd <= 1'b0;
  endtask : rd
  task automatic chkVal(input logic [15:0] g, input logic [15:0] e, input string m);
    nTests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chkVal
  task automatic chkOk(input logic c, input string m);
    nTests++;
    if (c !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chkOk
  task automatic give_verdict();
    if (fails == 0 && nTests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Read answers against the oldest note
  always @(posedge clk) begin
    if (rdPend) chkVal(regRdData, rdQ.pop_front(), "read");
    rdPend <= regRd;
  end
  // Samples: phase from the expected accumulator, data from the chosen port
  always @(posedge clk) begin
    if (outValid && outReady && !srst) begin
      gotCnt++;
      phExp = accExp[31:16] + offExp;
      accExp = accExp + wExp;
      chkVal(outSample.phase, phExp, "phase");
      if (ctrlExp[CTL_BYPASS]) begin
        ok = outSample.quadrature === {~outSample.inPhase.mantissa, 3'h6} && outSample.inPhase.exponent === 3'h1;
        chkOk(ok, "bypass");
      end else begin
        ok = outSample.inPhase.exponent === (ctrlExp[CTL_PORT_B] ? 3'h6 : 3'h1);
        ok = ok || (outSample.inPhase === '0 && ctrlExp[5:4] == 2'b00);
        chkOk(ok && outSample.quadrature === '0, "port");
      end
    end
  end
  // Qualifying enable events expected for the running mode
  always @(posedge clk) begin
    enSel = ctrlExp[CTL_PORT_B] ? sampleEnB : sampleEnA;
    if (cnting) begin
      case (ctrlExp[5:4])
        2'b00: expCnt++;
        2'b01: expCnt += enSel;
        2'b10: expCnt += (enSel && !enPrev);
        default: expCnt += (!enSel && enPrev);
      endcase
    end
    enPrev = enSel;
  end
  initial begin
    void'($urandom(21264));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int r = 0; r < 5; r++) begin
      stall = (r == 0);
      ctrlExp = runCtl[r];
      wExp = $urandom;
      offExp = 16'($urandom);
      // hold-off one applies the shadow at once
      wr(ADDR_HOLD_OFF, HOLD_NOW);
      wr(ADDR_CONTROL, {7'h00, ctrlExp});
      rd(ADDR_CONTROL, {7'h00, ctrlExp});
      wr(ADDR_TUNE_LO, wExp[15:0]);
      rd(ADDR_TUNE_LO, wExp[15:0]);
      wr(ADDR_TUNE_HI, wExp[31:16]);
      rd(ADDR_TUNE_HI, wExp[31:16]);
      wr(ADDR_PHASE, offExp);
      rd(ADDR_PHASE, offExp);
      // hop, clearing when bit 3 set
      if (r == 2) begin
        wr(ADDR_HOLD_OFF, 16'h0005);
        wr(ADDR_PIN_SYNC, 16'(1 << SYNC_HOP_BIT));
        syncPins[ctrlExp[CTL_SYNC_HI:CTL_SYNC_LO]] <= 1'b1;
        repeat (12) @(posedge clk);
        syncPins <= 4'h0;
      end else wr(ADDR_SOFT_SYNC, 16'(1 << SYNC_HOP_BIT));
      if (ctrlExp[CTL_CLR_ACC]) accExp = 32'h0;
      wr(ADDR_HOLD_OFF, HOLD_NONE);
      gotCnt = 0;
      expCnt = 0;
      wr(ADDR_SLEEP, 16'h0000);
      cnting = 1'b1;
      repeat (100) @(posedge clk);
      // shadow write while running stays in the shadow
      wr(ADDR_TUNE_LO, 16'($urandom));
      // hop under hold-off zero is void
      wr(ADDR_SOFT_SYNC, 16'(1 << SYNC_HOP_BIT));
      repeat (100) @(posedge clk);
      wr(ADDR_SLEEP, 16'h0001);
      cnting = 1'b0;
      stall = 1'b0;
      repeat (30) @(posedge clk);
      if (r != 0) chkOk((gotCnt - expCnt) inside {[-4:4]}, "count");
      // Stalled run loses samples; bit 0 write clears the flag
      if (r == 0) begin
        rd(ADDR_STATUS, 16'h0001);
        wr(ADDR_STATUS, 16'h0001);
        rd(ADDR_STATUS, 16'h0000);
      end
    end
    rd(8'h8f, 16'h0000);
    repeat (3) @(posedge clk);
    give_verdict();
  end
  // Watchdog far beyond the expected run
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
endmodule : channel_osc_ctrl_tb_top
`default_nettype wire
